// [verilog/ref_clock_pkg.sv]
// constants for reference clock selection, trim and clock request
package ref_clock_pkg;
	// frequency is carried in units of 80 Hz steps (synthesizer resolution)
	localparam int          FREQ_W          = 20;
	localparam int          STEP_HZ         = 80;
	localparam logic [19:0] FREQ_DEFAULT    = 20'h3D090;   // 20 MHz / 80 Hz = 250000
	localparam logic [19:0] FREQ_MIN        = 20'h249F0;   // 12 MHz / 80 Hz = 150000
	localparam logic [19:0] FREQ_MAX        = 20'h9EB10;   // 52 MHz / 80 Hz = 650000
	// trim in 2 ppm steps, signed, covering +/-50 ppm
	localparam int          TRIM_W          = 6;
	localparam int          TRIM_PPM_STEP   = 2;
	localparam int          TRIM_RANGE_PPM  = 50;
	localparam logic signed [5:0] TRIM_MAX  = 6'sh19;       // +25 steps = +50 ppm
	localparam logic signed [5:0] TRIM_MIN  = -6'sh19;
	localparam logic signed [5:0] TRIM_RESET = 6'sh00;
	// auto-detect: reference cycles counted over one low-power clock period
	localparam int          LP_CLK_HZ       = 32768;
	localparam int          CNT_W           = 12;
	localparam int          STD_COUNT       = 17;
	localparam int          CNT_TOL         = 2;
	// standard frequencies in 80 Hz units (12 ... 38.4 MHz)
	localparam logic [19:0] STD_FREQ [STD_COUNT] = '{
		20'h249F0, 20'h27AC4, 20'h2BF20, 20'h2EE00, 20'h31722, 20'h33450,
		20'h36EE8, 20'h3A980, 20'h3B57C, 20'h3C0B4, 20'h3C6F4, 20'h3D090,
		20'h493E0, 20'h4F588, 20'h668A0, 20'h7222C, 20'h75300};
	// source of the active frequency
	typedef enum logic [1:0] {
		SRC_DEFAULT = 2'h0,
		SRC_STORE   = 2'h1,
		SRC_DETECT  = 2'h2
	} freq_src_t;
	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_LOAD   = 5'h02,
		ST_ALIGN  = 5'h04,
		ST_COUNT  = 5'h08,
		ST_RUN    = 5'h10
	} sel_state_t;
endpackage

// [verilog/ref_cycle_counter.sv]
// counts reference cycles between two low-power clock rising edges
`timescale 1ns/10ps
`default_nettype none
module ref_cycle_counter
	import ref_clock_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// control
	input  wire logic              clear,
	input  wire logic              lp_edge,
	// result
	output logic [CNT_W-1:0]       count_r,
	output logic                   done_r
);
	logic [CNT_W-1:0] run_r;
	logic             armed_r;
	wire              saturated = &run_r;

	always_ff @(posedge core_clk) begin
		if (rst || clear) begin
			run_r   <= '0;
			armed_r <= 1'b0;
			count_r <= '0;
			done_r  <= 1'b0;
		end else if (lp_edge) begin
			armed_r <= 1'b1;
			run_r   <= '0;
			if (armed_r) begin
				count_r <= run_r;
				done_r  <= 1'b1;
			end
		end else if (!saturated) begin
			run_r <= run_r + 1'b1;
		end
	end
endmodule
`default_nettype wire

// [verilog/ref_clock_select_request.sv]
// reference frequency selection, digital trim and clock request output
`timescale 1ns/10ps
`default_nettype none
module ref_clock_select_request
	import ref_clock_pkg::*;
(
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	// power-on configuration download
	input  wire logic                     store_done,
	input  wire logic                     store_freq_valid,
	input  wire logic [FREQ_W-1:0]        store_freq,
	input  wire logic                     store_trim_valid,
	input  wire logic signed [TRIM_W-1:0] store_trim,
	// host trim command
	input  wire logic                     host_trim_stb,
	input  wire logic signed [TRIM_W-1:0] host_trim,
	// low-power clock
	input  wire logic                     ext_lp_clk,
	input  wire logic                     ext_lp_valid,
	input  wire logic                     low_power_oscillator,
	// power state and pad options
	input  wire logic                     awake,
	input  wire logic                     req_or_enable,
	input  wire logic                     req_pin_gp_mode,
	input  wire logic                     req_pin_gp_out,
	input  wire logic                     clk_req_in,
	// configured reference
	output logic [FREQ_W-1:0]             ref_freq_r,
	output logic signed [TRIM_W-1:0]      ref_trim_r,
	output logic [FREQ_W-1:0]             bit_timing_freq_r,
	output freq_src_t                     freq_src_r,
	output logic                          config_ready_r,
	output logic                          freq_reject_r,
	// timing reference and pad
	output logic                          sleep_tick_src_ext_r,
	output logic                          sleep_tick_r,
	output logic                          clk_req_out_r
);
	////////////////////////////////////////////////////////////////////////////
	// synchronisers: three stages, a change counts when stages two and three agree
	logic [2:0] lp_sync_r;
	logic [2:0] lpv_sync_r;
	logic [2:0] osc_sync_r;
	logic [2:0] req_sync_r;
	logic       lp_lvl_r;
	logic       lpv_lvl_r;
	logic       osc_lvl_r;
	logic       req_lvl_r;

	// the pin synchronisers carry no reset; stages two and three settle
	// within three cycles of release anyway
	always_ff @(posedge core_clk) begin
		lp_sync_r  <= {lp_sync_r[1:0], ext_lp_clk};
		lpv_sync_r <= {lpv_sync_r[1:0], ext_lp_valid};
		osc_sync_r <= {osc_sync_r[1:0], low_power_oscillator};
		req_sync_r <= {req_sync_r[1:0], clk_req_in};
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			lp_lvl_r  <= 1'b0;
			lpv_lvl_r <= 1'b0;
			osc_lvl_r <= 1'b0;
			req_lvl_r <= 1'b0;
		end else begin
			if (lp_sync_r[1] == lp_sync_r[2])
				lp_lvl_r <= lp_sync_r[2];
			if (lpv_sync_r[1] == lpv_sync_r[2])
				lpv_lvl_r <= lpv_sync_r[2];
			if (osc_sync_r[1] == osc_sync_r[2])
				osc_lvl_r <= osc_sync_r[2];
			if (req_sync_r[1] == req_sync_r[2])
				req_lvl_r <= req_sync_r[2];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// low-power clock edge selection
	logic lp_prev_r;
	wire  lp_rise = lp_lvl_r & ~lp_prev_r;

	always_ff @(posedge core_clk) begin
		if (rst)
			lp_prev_r <= 1'b0;
		else
			lp_prev_r <= lp_lvl_r;
	end

	////////////////////////////////////////////////////////////////////////////
	// frequency measurement
	// one low-power period is only 30.5 us of core clock, so the count is a
	// coarse ratio; it only needs to pick the nearest standard frequency
	logic             meas_clear;
	logic [CNT_W-1:0] meas_count;
	logic             meas_done;

	ref_cycle_counter u_counter (
		.core_clk (core_clk),
		.rst      (rst),
		.clear    (meas_clear),
		.lp_edge  (lp_rise),
		.count_r  (meas_count),
		.done_r   (meas_done)
	);

	// expected count for each standard frequency: f / 32768 in core cycles,
	// scaled since the reference itself is modelled by its cycle ratio
	logic [STD_COUNT-1:0] std_hit;
	logic [FREQ_W-1:0]    std_pick;
	logic                 std_found;

	// ideal count is the frequency over 32768 Hz; the tolerance absorbs
	// the 50 and 250 ppm drift plus synchroniser jitter
	genvar g;
	generate
		for (g = 0; g < STD_COUNT; g++) begin : g_std
			localparam logic [31:0] EXP32 = (32'(STD_FREQ[g]) * STEP_HZ) / LP_CLK_HZ;
			localparam logic [CNT_W-1:0] EXP = EXP32[CNT_W-1:0];
			assign std_hit[g] = (meas_count + CNT_TOL[CNT_W-1:0] >= EXP) &&
				(meas_count <= EXP + CNT_TOL[CNT_W-1:0]);
		end
	endgenerate

	always_comb begin
		std_pick  = FREQ_DEFAULT;
		std_found = 1'b0;
		for (int i = STD_COUNT - 1; i >= 0; i--) begin
			if (std_hit[i]) begin
				std_pick  = STD_FREQ[i];
				std_found = 1'b1;
			end
		end
	end

	// the internal oscillator is a level input; one tick per rising edge,
	// so a stuck-high oscillator does not look like a tick every cycle
	logic osc_prev_r;
	wire  osc_rise = osc_lvl_r & ~osc_prev_r;

	always_ff @(posedge core_clk) begin
		if (rst)
			osc_prev_r <= 1'b0;
		else
			osc_prev_r <= osc_lvl_r;
	end

	////////////////////////////////////////////////////////////////////////////
	// selection state machine
	// one pass per reset: only rst leaves RUN, so the selection is frozen
	// once config_ready_r rises
	sel_state_t state_r;
	sel_state_t state_nxt;

	wire store_freq_ok = store_freq_valid &&
		(store_freq >= FREQ_MIN) && (store_freq <= FREQ_MAX);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:  state_nxt = ST_LOAD;
			ST_LOAD: begin
				if (store_done) begin
					if (store_freq_ok)
						state_nxt = ST_RUN;
					else if (lpv_lvl_r)
						state_nxt = ST_ALIGN;
					else
						state_nxt = ST_RUN;
				end
			end
			ST_ALIGN: state_nxt = ST_COUNT;
			ST_COUNT: begin
				if (meas_done || !lpv_lvl_r)
					state_nxt = ST_RUN;
			end
			ST_RUN:   state_nxt = ST_RUN;
			default:  state_nxt = ST_IDLE;
		endcase
	end

	assign meas_clear = (state_r != ST_COUNT);

	always_ff @(posedge core_clk) begin
		if (rst)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// frequency and trim registers
	// detection falls back to the default if the count matches no standard value
	wire load_done  = (state_r == ST_LOAD) && store_done;
	wire count_done = (state_r == ST_COUNT) && (meas_done || !lpv_lvl_r);
	wire detect_ok  = meas_done && lpv_lvl_r && std_found;

	// out-of-range trims saturate rather than wrap, so a bad value never
	// flips the sign of the correction
	function automatic logic signed [TRIM_W-1:0] clamp_trim(
		input logic signed [TRIM_W-1:0] t
	);
		if (t > TRIM_MAX)
			return TRIM_MAX;
		else if (t < TRIM_MIN)
			return TRIM_MIN;
		else
			return t;
	endfunction

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ref_freq_r     <= FREQ_DEFAULT;
			freq_src_r     <= SRC_DEFAULT;
			freq_reject_r  <= 1'b0;
			config_ready_r <= 1'b0;
		end else begin
			if (load_done && store_freq_ok) begin
				ref_freq_r <= store_freq;
				freq_src_r <= SRC_STORE;
			end
			if (load_done && store_freq_valid && !store_freq_ok)
				freq_reject_r <= 1'b1;
			if (count_done && detect_ok) begin
				ref_freq_r <= std_pick;
				freq_src_r <= SRC_DETECT;
			end
			if (state_nxt == ST_RUN)
				config_ready_r <= 1'b1;
		end
	end

	// trim held as signed 2 ppm steps; the synthesizer applies it, the
	// oscillator loading never changes
	always_ff @(posedge core_clk) begin
		if (rst)
			ref_trim_r <= TRIM_RESET;
		else if (host_trim_stb)
			ref_trim_r <= clamp_trim(host_trim);
		else if (load_done && store_trim_valid)
			ref_trim_r <= clamp_trim(store_trim);
	end

	// serial bit timing follows whatever frequency is configured
	always_ff @(posedge core_clk) begin
		if (rst)
			bit_timing_freq_r <= FREQ_DEFAULT;
		else
			bit_timing_freq_r <= ref_freq_r;
	end

	////////////////////////////////////////////////////////////////////////////
	// sleep timing reference
	// ticks run only while asleep; awake timing uses the main reference
	wire lp_tick_sel = lpv_lvl_r ? lp_rise : osc_rise;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sleep_tick_src_ext_r <= 1'b0;
			sleep_tick_r         <= 1'b0;
		end else begin
			sleep_tick_src_ext_r <= lpv_lvl_r;
			sleep_tick_r         <= ~awake & lp_tick_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// clock request pad
	// the OR here models the pad-ring gate; the real gate lives in the pad and
	// keeps working with the core off, which this register path cannot
	wire int_req   = awake;
	wire or_req    = int_req | (req_or_enable & req_lvl_r);
	wire pad_value = req_pin_gp_mode ? req_pin_gp_out : or_req;

	always_ff @(posedge core_clk) begin
		if (rst)
			clk_req_out_r <= 1'b0;
		else
			clk_req_out_r <= pad_value;
	end
endmodule
`default_nettype wire

// [testbench/ref_clock_select_request_asserts.sv]
// port assertions for the reference clock select and request block
`timescale 1ns/10ps
`default_nettype none
module ref_clock_select_request_asserts
	import ref_clock_pkg::*;
(
	// clock and reset
	input wire logic                     core_clk,
	input wire logic                     rst,
	// inputs watched
	input wire logic                     host_trim_stb,
	input wire logic signed [TRIM_W-1:0] host_trim,
	input wire logic                     awake,
	input wire logic                     req_or_enable,
	input wire logic                     req_pin_gp_mode,
	input wire logic                     clk_req_in,
	// outputs watched
	input wire logic [FREQ_W-1:0]        ref_freq_r,
	input wire logic signed [TRIM_W-1:0] ref_trim_r,
	input wire logic [FREQ_W-1:0]        bit_timing_freq_r,
	input wire freq_src_t                freq_src_r,
	input wire logic                     config_ready_r,
	input wire logic                     clk_req_out_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	// six cycles covers the request input synchronizer
	sequence s_ext_req; (req_or_enable && clk_req_in && !req_pin_gp_mode)[*6]; endsequence
	sequence s_idle; (!awake && !req_or_enable && !req_pin_gp_mode)[*2]; endsequence
	property p_wake; $rose(awake) && !req_pin_gp_mode |=> clk_req_out_r; endproperty
	a_wake: assert property (p_wake) else $error("no request after wake");
	property p_sleep; s_idle |-> !clk_req_out_r; endproperty
	a_sleep: assert property (p_sleep) else $error("request while asleep");
	property p_or; s_ext_req |-> clk_req_out_r; endproperty
	a_or: assert property (p_or) else $error("external request not merged");
	property p_trim;
		host_trim_stb && host_trim <= TRIM_MAX && host_trim >= TRIM_MIN
		|=> ref_trim_r == $past(host_trim);
	endproperty
	a_trim: assert property (p_trim) else $error("host trim not applied");
	property p_clamp; host_trim_stb && host_trim > TRIM_MAX |=> ref_trim_r == TRIM_MAX; endproperty
	a_clamp: assert property (p_clamp) else $error("trim not clamped");
	property p_timing; $changed(ref_freq_r) |=> bit_timing_freq_r == $past(ref_freq_r); endproperty
	a_timing: assert property (p_timing) else $error("bit timing lags wrong");
	property p_default;
		config_ready_r && freq_src_r == SRC_DEFAULT |-> ref_freq_r == FREQ_DEFAULT;
	endproperty
	a_default: assert property (p_default) else $error("default not 20 MHz");
	property p_range;
		config_ready_r && freq_src_r == SRC_STORE |-> ref_freq_r >= FREQ_MIN && ref_freq_r <= FREQ_MAX;
	endproperty
	a_range: assert property (p_range) else $error("stored freq out of range");
	property p_hold; config_ready_r |=> config_ready_r && $stable(ref_freq_r); endproperty
	a_hold: assert property (p_hold) else $error("selection changed");
endmodule
bind ref_clock_select_request ref_clock_select_request_asserts i_ref_clock_select_request_asserts (
	.core_clk(core_clk), .rst(rst), .host_trim_stb(host_trim_stb), .host_trim(host_trim),
	.awake(awake), .req_or_enable(req_or_enable), .req_pin_gp_mode(req_pin_gp_mode),
	.clk_req_in(clk_req_in), .ref_freq_r(ref_freq_r), .ref_trim_r(ref_trim_r),
	.bit_timing_freq_r(bit_timing_freq_r), .freq_src_r(freq_src_r),
	.config_ready_r(config_ready_r), .clk_req_out_r(clk_req_out_r));
`default_nettype wire

// [testbench/sys_clk_partner.sv]
// system request source and external low-power clock
`timescale 1ns/10ps
`default_nettype none
module sys_clk_partner
(
	// control from the bench
	input  wire logic sys_need,
	// lines toward the block
	output logic      clk_req_in,
	output logic      ext_lp_clk
);
	////////////////////////////////////////////////////////////
	// always a definite level, never floating
	assign clk_req_in = sys_need;
	// free-running 32.768 kHz, far inside 250 ppm
	initial begin
		ext_lp_clk = 1'b0;
		forever #15259 ext_lp_clk = ~ext_lp_clk;
	end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for reference selection, trim and clock request
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import ref_clock_pkg::*;
	logic                     core_clk, rst, store_done, store_freq_valid, store_trim_valid;
	logic                     host_trim_stb, awake, req_or_enable, sys_need, clk_req_in;
	logic                     ext_lp_clk, config_ready_r, freq_reject_r, clk_req_out_r;
	logic                     ext_lp_valid, low_power_oscillator, req_pin_gp_mode;
	logic                     req_pin_gp_out, sleep_tick_src_ext_r, sleep_tick_r;
	logic [FREQ_W-1:0]        store_freq, ref_freq_r, bit_timing_freq_r;
	logic signed [TRIM_W-1:0] store_trim, host_trim, ref_trim_r;
	freq_src_t                freq_src_r;
	int                       mismatches, tests_run;
	// every input is driven so pad, tick and priority rules are reachable
	ref_clock_select_request i_ref_clock_select_request (
		.core_clk(core_clk), .rst(rst), .store_done(store_done),
		.store_freq_valid(store_freq_valid), .store_freq(store_freq),
		.store_trim_valid(store_trim_valid), .store_trim(store_trim),
		.host_trim_stb(host_trim_stb), .host_trim(host_trim), .ext_lp_clk(ext_lp_clk),
		.ext_lp_valid(ext_lp_valid), .low_power_oscillator(low_power_oscillator),
		.awake(awake), .req_or_enable(req_or_enable), .req_pin_gp_mode(req_pin_gp_mode),
		.req_pin_gp_out(req_pin_gp_out),
		.clk_req_in(clk_req_in), .ref_freq_r(ref_freq_r), .ref_trim_r(ref_trim_r),
		.bit_timing_freq_r(bit_timing_freq_r), .freq_src_r(freq_src_r),
		.config_ready_r(config_ready_r), .freq_reject_r(freq_reject_r),
		.sleep_tick_src_ext_r(sleep_tick_src_ext_r), .sleep_tick_r(sleep_tick_r),
		.clk_req_out_r(clk_req_out_r));
	sys_clk_partner i_sys_clk_partner (
		.sys_need(sys_need), .clk_req_in(clk_req_in), .ext_lp_clk(ext_lp_clk));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [FREQ_W-1:0] got, input logic [FREQ_W-1:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// n rising edges, then sample at the falling edge once outputs settle
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic do_reset(input logic fv, input logic [FREQ_W-1:0] f, input logic tv,
			input logic signed [TRIM_W-1:0] t);
		int i;
		@(posedge core_clk);
		rst <= 1'b1;
		store_freq_valid <= fv;
		store_freq <= f;
		store_trim_valid <= tv;
		store_trim <= t;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		store_done <= 1'b1;
		for (i = 0; i < 20 && config_ready_r !== 1'b1; i++) @(posedge core_clk);
		store_done <= 1'b0;
		if (config_ready_r !== 1'b1) begin
			mismatches++;
			complete_run();
		end
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_defaults;
		do_reset(1'b0, FREQ_MAX, 1'b0, 6'sh00);
		settle(0);
		chk(ref_freq_r, FREQ_DEFAULT);
		chk(freq_src_r, SRC_DEFAULT);
		chk(clk_req_out_r, 1'b0);
	endtask
	task automatic t_stored;
		logic [FREQ_W-1:0] fl[5] = '{FREQ_MIN, 20'h3D0A5, FREQ_MAX, 20'h249EF, 20'h9EB11};
		logic              ok;
		for (int k = 0; k < 5; k++) begin
			ok = fl[k] >= FREQ_MIN && fl[k] <= FREQ_MAX;
			do_reset(1'b1, fl[k], 1'b1, -6'sh05);
			settle(0);
			chk(ref_freq_r, ok ? fl[k] : FREQ_DEFAULT);
			chk(freq_src_r, ok ? SRC_STORE : SRC_DEFAULT);
			chk(freq_reject_r, !ok);
			chk(ref_trim_r, -6'sh05);
			settle(1);
			chk(bit_timing_freq_r, ok ? fl[k] : FREQ_DEFAULT);
		end
	endtask
	// strobe held high so the writes arrive back to back
	task automatic t_trim;
		logic signed [TRIM_W-1:0] v[4] = '{6'sh07, 6'sh1F, -6'sh20, -6'sh19};
		logic signed [TRIM_W-1:0] e[4] = '{6'sh07, TRIM_MAX, TRIM_MIN, TRIM_MIN};
		for (int k = 0; k < 4; k++) begin
			@(posedge core_clk);
			host_trim_stb <= 1'b1;
			host_trim <= v[k];
			settle(1);
			chk(ref_trim_r, e[k]);
		end
		@(posedge core_clk);
		host_trim_stb <= 1'b0;
	endtask
	// steps of {awake, or enable, system need, expected pad}
	task automatic t_request;
		logic [3:0] s[7] = '{4'h9, 4'h0, 4'h2, 4'h7, 4'hF, 4'hD, 4'h4};
		for (int k = 0; k < 7; k++) begin
			@(posedge core_clk);
			awake <= s[k][3];
			req_or_enable <= s[k][2];
			sys_need <= s[k][1];
			settle(6);
			chk(clk_req_out_r, s[k][0]);
		end
	endtask
	// stored value beats a valid low-power clock; then sleep ticks and pin reuse
	task automatic t_lowpower;
		int n;
		@(posedge core_clk);
		ext_lp_valid <= 1'b1;
		do_reset(1'b1, FREQ_MIN, 1'b0, 6'sh00);
		settle(0);
		chk(freq_src_r, SRC_STORE);
		chk(sleep_tick_src_ext_r, 1'b1);
		for (n = 0; n < 8000 && sleep_tick_r !== 1'b1; n++) settle(1);
		chk(sleep_tick_r, 1'b1);
		if (sleep_tick_r !== 1'b1)
			complete_run();
		settle(1);
		chk(sleep_tick_r, 1'b0);
		@(posedge core_clk);
		ext_lp_valid <= 1'b0;
		low_power_oscillator <= 1'b1;
		settle(5);
		chk(sleep_tick_r, 1'b1);
		chk(sleep_tick_src_ext_r, 1'b0);
		@(posedge core_clk);
		req_pin_gp_mode <= 1'b1;
		req_pin_gp_out <= 1'b1;
		settle(1);
		chk(clk_req_out_r, 1'b1);
		@(posedge core_clk);
		awake <= 1'b1;
		req_pin_gp_out <= 1'b0;
		settle(1);
		chk(clk_req_out_r, 1'b0);
		@(posedge core_clk);
		req_pin_gp_mode <= 1'b0;
		settle(1);
		chk(clk_req_out_r, 1'b1);
	endtask
	initial begin
		mismatches = 0;
		tests_run = 0;
		rst = 1'b1;
		store_done = 1'b0;
		store_freq_valid = 1'b0;
		store_freq = '0;
		store_trim_valid = 1'b0;
		store_trim = '0;
		host_trim_stb = 1'b0;
		host_trim = '0;
		awake = 1'b0;
		req_or_enable = 1'b0;
		sys_need = 1'b0;
		ext_lp_valid = 1'b0;
		low_power_oscillator = 1'b0;
		req_pin_gp_mode = 1'b0;
		req_pin_gp_out = 1'b0;
		t_defaults();
		t_stored();
		t_trim();
		t_request();
		t_lowpower();
		complete_run();
	end
endmodule
`default_nettype wire
